// ==== design/acr_regs.sv ====
// Implementation choice: strobed register access.
module acr_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Detection core side
	input wire acr_pkg::acr_evt_t evt,
	input wire logic data_ready,
	input wire logic [10:0] y_trim_low_part,
	input wire logic window_nonzero,
	input wire logic latency_nonzero,
	output acr_pkg::acr_cfg_t cfg,
	output logic [7:0] detect_source,
	// Interrupt pins
	output logic first_irq_ready_pin,
	output logic second_irq_pin
);
	import acr_pkg::*;

	logic [7:0] y_offset_upper;
	logic [7:0] z_offset_lower;
	logic [7:0] z_offset_upper;
	logic [7:0] operating_mode_control;
	logic [7:0] interrupt_flag_clear;
	logic [7:0] detection_control_one;
	logic [2:0] x_level_flag_v; // x,y,z level flags packed
	logic [2:0] pulse_flag_v;
	logic first_irq;
	logic second_irq;
	logic clr1;
	logic clr2;
	logic [1:0] irq_source_assign;
	logic [2:0] en;
	logic [2:0] lvl_in;
	logic [2:0] pls_in;
	logic first_set;
	logic second_set;
	logic lvl_to1;
	logic lvl_to2;
	logic pls_to1;
	logic pls_to2;
	logic next_pin1;
	logic next_pin2;

	// Configuration writes; unused bits masked so they read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			y_offset_upper <= RESET_VALUE;
			z_offset_lower <= RESET_VALUE;
			z_offset_upper <= RESET_VALUE;
			operating_mode_control <= RESET_VALUE;
			detection_control_one <= RESET_VALUE;
		end else if (wr) begin
			unique case (addr)
				ADDR_Y_OFFSET_UPPER: y_offset_upper <= wdata & MASK_UPPER;
				ADDR_Z_OFFSET_LOWER: z_offset_lower <= wdata;
				ADDR_Z_OFFSET_UPPER: z_offset_upper <= wdata & MASK_UPPER;
				ADDR_MODE_CONTROL: operating_mode_control <= wdata & MASK_MODE;
				ADDR_DETECT_CTRL1: detection_control_one <= wdata;
				default: ;
			endcase
		end
	end

	// Clear register: a write stores the bits for readback, the action is one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_flag_clear <= RESET_VALUE;
		end else if (wr && addr == ADDR_FLAG_CLEAR) begin
			interrupt_flag_clear <= wdata & MASK_CLEAR;
		end
	end

	assign clr1 = wr && addr == ADDR_FLAG_CLEAR && wdata[0];
	assign clr2 = wr && addr == ADDR_FLAG_CLEAR && wdata[1];
	assign irq_source_assign = detection_control_one[2:1];
	// Event vectors run x,y,z from bit 2 down, while the disable bits run x,y,z upward,
	// so the enable vector is built reversed; a plain slice would mask the wrong axis
	assign en = {~detection_control_one[POS_X_DISABLE],
		~detection_control_one[POS_X_DISABLE + 1],
		~detection_control_one[POS_X_DISABLE + 2]};

	// Axis gating; vector order x,y,z maps to event bit order
	assign lvl_in = evt.level_hit & en;
	assign pls_in = evt.pulse_hit & en;

	// Which flag group each clear affects, by source assignment
	always_comb begin
		lvl_to1 = 1'b0;
		lvl_to2 = 1'b0;
		pls_to1 = 1'b0;
		pls_to2 = 1'b0;
		first_set = 1'b0;
		second_set = 1'b0;
		unique case (irq_source_assign)
			2'b00: begin
				lvl_to1 = 1'b1;
				pls_to2 = 1'b1;
				first_set = |lvl_in;
				second_set = |pls_in;
			end
			2'b01: begin
				pls_to1 = 1'b1;
				lvl_to2 = 1'b1;
				first_set = |pls_in;
				second_set = |lvl_in;
			end
			default: begin
				// Double pulse only when both latency and window are set
				pls_to1 = 1'b1;
				pls_to2 = 1'b1;
				first_set = |pls_in;
				second_set = (window_nonzero && latency_nonzero) ?
					|(evt.double_hit & en) : |pls_in;
			end
		endcase
	end

	// Sticky level flags; a new hit wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			x_level_flag_v <= 3'h0;
		end else begin
			x_level_flag_v <= (x_level_flag_v & ~{3{(clr1 && lvl_to1) || (clr2 && lvl_to2)}})
				| lvl_in;
		end
	end

	// Sticky pulse flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pulse_flag_v <= 3'h0;
		end else begin
			pulse_flag_v <= (pulse_flag_v & ~{3{(clr1 && pls_to1) || (clr2 && pls_to2)}})
				| pls_in;
		end
	end

	// Interrupt flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_irq <= 1'b0;
			second_irq <= 1'b0;
		end else begin
			first_irq <= (first_irq && !clr1) || first_set;
			second_irq <= (second_irq && !clr2) || second_set;
		end
	end

	// Pin routing; data ready merges onto the first pin unless suppressed
	always_comb begin
		next_pin1 = detection_control_one[POS_PIN_SWAP] ? second_irq : first_irq;
		next_pin2 = detection_control_one[POS_PIN_SWAP] ? first_irq : second_irq;
		if (!operating_mode_control[POS_READY_SUPPRESS]) begin
			next_pin1 = next_pin1 | data_ready;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_irq_ready_pin <= 1'b0;
			second_irq_pin <= 1'b0;
		end else begin
			first_irq_ready_pin <= next_pin1;
			second_irq_pin <= next_pin2;
		end
	end

	// Source register view registered for the output
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			detect_source <= 8'h00;
		end else begin
			detect_source <= {x_level_flag_v, pulse_flag_v, second_irq, first_irq};
		end
	end

	// Decoded configuration, registered so core sees a clean copy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= '0;
		end else begin
			cfg.mode <= acr_mode_t'(operating_mode_control[1:0]);
			cfg.range_select <= acr_range_t'(operating_mode_control[3:2]);
			unique case (operating_mode_control[3:2])
				2'b00: cfg.counts_per_g <= 7'h10;
				2'b01: cfg.counts_per_g <= 7'h40;
				2'b10: cfg.counts_per_g <= 7'h20;
				default: cfg.counts_per_g <= 7'h10;
			endcase
			cfg.self_test_on <= operating_mode_control[POS_SELF_TEST];
			cfg.three_wire_select <= operating_mode_control[POS_THREE_WIRE];
			cfg.filter_bandwidth_select <= detection_control_one[POS_BW];
			cfg.threshold_sign_option <= detection_control_one[POS_THR_SIGN];
			cfg.axis_enable <= en;
			cfg.y_trim_value <= {y_offset_upper[2:0], y_trim_low_part[7:0]};
			cfg.z_trim_value <= {z_offset_upper[2:0], z_offset_lower};
		end
	end

	// Read data one cycle after strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				ADDR_Y_OFFSET_UPPER: rdata <= y_offset_upper;
				ADDR_Z_OFFSET_LOWER: rdata <= z_offset_lower;
				ADDR_Z_OFFSET_UPPER: rdata <= z_offset_upper;
				ADDR_MODE_CONTROL: rdata <= operating_mode_control;
				ADDR_FLAG_CLEAR: rdata <= interrupt_flag_clear;
				ADDR_DETECT_CTRL1: rdata <= detection_control_one;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Clear of first flag with no new source event drops it next cycle
	clear_first_a: assert property (@(posedge clk) disable iff (!rstn)
		clr1 && !first_set |=> !first_irq) else $error("first flag not cleared");
	clear_second_a: assert property (@(posedge clk) disable iff (!rstn)
		clr2 && !second_set |=> !second_irq) else $error("second flag not cleared");
	set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
		first_set |=> first_irq) else $error("first flag event lost");
	swap_route_a: assert property (@(posedge clk) disable iff (!rstn)
		detection_control_one[POS_PIN_SWAP] |=> second_irq_pin == $past(first_irq))
		else $error("swapped pin wrong");
	plain_route_a: assert property (@(posedge clk) disable iff (!rstn)
		!detection_control_one[POS_PIN_SWAP] |=> second_irq_pin == $past(second_irq))
		else $error("second pin wrong");
	ready_hidden_a: assert property (@(posedge clk) disable iff (!rstn)
		operating_mode_control[POS_READY_SUPPRESS] && !detection_control_one[POS_PIN_SWAP]
		|=> first_irq_ready_pin == $past(first_irq)) else $error("ready leaked");
	axis_off_a: assert property (@(posedge clk) disable iff (!rstn)
		detection_control_one[POS_X_DISABLE + 2] && !x_level_flag_v[0] && !wr
		|=> !x_level_flag_v[0]) else $error("disabled axis flagged");
	level_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		x_level_flag_v[2] && !clr1 && !clr2 |=> x_level_flag_v[2])
		else $error("level flag lost");
	mode_reg_a: assert property (@(posedge clk) disable iff (!rstn)
		wr && addr == ADDR_MODE_CONTROL ##1 !wr |=> cfg.self_test_on == $past(wdata[4], 2))
		else $error("self test not followed");
	range_2g_a: assert property (@(posedge clk) disable iff (!rstn)
		operating_mode_control[3:2] == 2'b01 |=> cfg.counts_per_g == 7'h40)
		else $error("range count wrong");

	// Remaining valid range codes; a wrong count scales every reading
	range_8g_a: assert property (@(posedge clk) disable iff (!rstn)
		operating_mode_control[3:2] == 2'b00 |=> cfg.counts_per_g == 7'h10)
		else $error("8g count wrong");
	range_4g_a: assert property (@(posedge clk) disable iff (!rstn)
		operating_mode_control[3:2] == 2'b10 |=> cfg.counts_per_g == 7'h20)
		else $error("4g count wrong");

	// Unused register bits must never hold a one
	y_upper_mask_a: assert property (@(posedge clk) disable iff (!rstn)
		y_offset_upper[7:3] == 5'h00) else $error("y upper spare bits set");
	z_upper_mask_a: assert property (@(posedge clk) disable iff (!rstn)
		z_offset_upper[7:3] == 5'h00) else $error("z upper spare bits set");
	mode_spare_a: assert property (@(posedge clk) disable iff (!rstn)
		!operating_mode_control[7]) else $error("mode spare bit set");
	clear_spare_a: assert property (@(posedge clk) disable iff (!rstn)
		interrupt_flag_clear[7:2] == 6'h00) else $error("clear spare bits set");

	// Trim words join the upper three bits onto the lower byte
	y_trim_join_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.y_trim_value == {$past(y_offset_upper[2:0]), $past(y_trim_low_part[7:0])})
		else $error("y trim joined wrong");
	z_trim_join_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.z_trim_value == {$past(z_offset_upper[2:0]), $past(z_offset_lower)})
		else $error("z trim joined wrong");

	// Decoded configuration follows its register bits one cycle later
	mode_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.mode == $past(operating_mode_control[1:0]))
		else $error("mode not followed");
	test_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.self_test_on == $past(operating_mode_control[POS_SELF_TEST]))
		else $error("self test bit not followed");
	wire_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.three_wire_select == $past(operating_mode_control[POS_THREE_WIRE]))
		else $error("wire count not followed");
	bw_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.filter_bandwidth_select == $past(detection_control_one[POS_BW]))
		else $error("bandwidth not followed");
	thr_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.threshold_sign_option == $past(detection_control_one[POS_THR_SIGN]))
		else $error("threshold option not followed");
	axis_cfg_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cfg.axis_enable == $past(en))
		else $error("axis enables not followed");

	// Source assignment decides which detector raises the first flag
	assign_lvl_a: assert property (@(posedge clk) disable iff (!rstn)
		irq_source_assign == 2'b00 && |lvl_in |=> first_irq)
		else $error("level did not raise first flag");
	assign_pls_a: assert property (@(posedge clk) disable iff (!rstn)
		irq_source_assign == 2'b01 && |pls_in |=> first_irq)
		else $error("pulse did not raise first flag");
	// With both timings set, a lone single pulse must not raise the second flag
	double_only_a: assert property (@(posedge clk) disable iff (!rstn)
		irq_source_assign[1] && window_nonzero && latency_nonzero
		&& !(|(evt.double_hit & en)) && !second_irq |=> !second_irq)
		else $error("single pulse raised second flag");

	// Clears empty the flag group routed to them when no new hit arrives
	level_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		clr1 && lvl_to1 && !(|lvl_in) |=> x_level_flag_v == 3'h0)
		else $error("level flags not cleared");
	pulse_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		clr2 && pls_to2 && !(|pls_in) |=> pulse_flag_v == 3'h0)
		else $error("pulse flags not cleared");
	zero_write_a: assert property (@(posedge clk) disable iff (!rstn)
		wr && addr == ADDR_FLAG_CLEAR && !wdata[0] && first_irq |=> first_irq)
		else $error("zero write cleared flag");
	ready_shown_a: assert property (@(posedge clk) disable iff (!rstn)
		!operating_mode_control[POS_READY_SUPPRESS] && data_ready |=> first_irq_ready_pin)
		else $error("ready not shown");
endmodule

// ==== common/acr_pkg.sv ====
package acr_pkg;
	localparam logic [7:0] ADDR_Y_OFFSET_UPPER = 8'h13;
	localparam logic [7:0] ADDR_Z_OFFSET_LOWER = 8'h14;
	localparam logic [7:0] ADDR_Z_OFFSET_UPPER = 8'h15;
	localparam logic [7:0] ADDR_MODE_CONTROL = 8'h16;
	localparam logic [7:0] ADDR_FLAG_CLEAR = 8'h17;
	localparam logic [7:0] ADDR_DETECT_CTRL1 = 8'h18;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Writable bit masks; other bits read zero
	localparam logic [7:0] MASK_UPPER = 8'h07;
	localparam logic [7:0] MASK_MODE = 8'h7f;
	localparam logic [7:0] MASK_CLEAR = 8'h03;
	// Field positions in mode control
	localparam int POS_SELF_TEST = 4;
	localparam int POS_THREE_WIRE = 5;
	localparam int POS_READY_SUPPRESS = 6;
	// Field positions in detection control one
	localparam int POS_PIN_SWAP = 0;
	localparam int POS_X_DISABLE = 3;
	localparam int POS_BW = 7;
	localparam int POS_THR_SIGN = 6;

	typedef enum logic [1:0] {ACR_STANDBY, ACR_MEASURE, ACR_LEVEL, ACR_PULSE} acr_mode_t;
	typedef enum logic [1:0] {ACR_R8G, ACR_R2G, ACR_R4G, ACR_RBAD} acr_range_t;

	// Decoded configuration handed to the sensing core
	typedef struct packed {
		acr_mode_t mode;
		acr_range_t range_select;
		logic [6:0] counts_per_g;
		logic self_test_on;
		logic three_wire_select;
		logic filter_bandwidth_select;
		logic threshold_sign_option;
		logic [2:0] axis_enable;
		logic [10:0] y_trim_value;
		logic [10:0] z_trim_value;
	} acr_cfg_t;

	// Detection events from the core, one-cycle pulses per axis x,y,z
	typedef struct packed {
		logic [2:0] level_hit;
		logic [2:0] pulse_hit;
		logic [2:0] double_hit;
	} acr_evt_t;
endpackage

// ==== bench/acr_core_model.sv ====
module acr_core_model (
	// Clock
	input wire logic clk,
	// Core side toward the register block
	output acr_pkg::acr_evt_t evt,
	output logic data_ready,
	output logic [10:0] y_trim_low_part,
	output logic window_nonzero,
	output logic latency_nonzero
);
	import acr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet core; a zero window keeps every pulse a single one
	initial begin
		evt = '0;
		data_ready = 1'b0;
		y_trim_low_part = 11'h0a5;
		window_nonzero = 1'b0;
		latency_nonzero = 1'b0;
	end

	// One-cycle event, launched just after an edge
	task automatic hit(input acr_evt_t v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask

	// Timing levels stand for the outside latency and window registers
	task automatic set_timing(input logic w, input logic l);
		@(posedge clk);
		window_nonzero <= w;
		latency_nonzero <= l;
	endtask

	// Data ready is a level, so it stays until told otherwise
	task automatic set_ready(input logic b);
		@(posedge clk);
		data_ready <= b;
	endtask
endmodule

// ==== bench/acr_regs_tb.sv ====
module acr_regs_tb;
	import acr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rstn, wr, rd, data_ready, window_nonzero, latency_nonzero;
	logic [7:0] addr, wdata, rdata, detect_source;
	logic [10:0] y_trim_low_part;
	logic first_irq_ready_pin, second_irq_pin;
	acr_evt_t evt;
	acr_cfg_t cfg;
	int miscompares = 0;
	int num_checks = 0;

	acr_core_model core (.clk(clk), .evt(evt), .data_ready(data_ready),
		.y_trim_low_part(y_trim_low_part), .window_nonzero(window_nonzero),
		.latency_nonzero(latency_nonzero));

	acr_regs dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .evt(evt), .data_ready(data_ready),
		.y_trim_low_part(y_trim_low_part), .window_nonzero(window_nonzero),
		.latency_nonzero(latency_nonzero), .cfg(cfg), .detect_source(detect_source),
		.first_irq_ready_pin(first_irq_ready_pin), .second_irq_pin(second_irq_pin));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", {3'b0, exp}, {3'b0, rdata});
	endtask

	// Outputs trail a write or event by two edges; wait three
	task automatic look(input logic [7:0] ds, input logic [1:0] pins);
		repeat (3) @(posedge clk);
		#1;
		chk("detect_source", {3'b0, ds}, {3'b0, detect_source});
		chk("pins", {9'b0, pins}, {9'b0, first_irq_ready_pin, second_irq_pin});
	endtask

	task automatic t_reset;
		for (int i = 0; i < 6; i++)
			rchk(8'h13 + 8'(i), 8'h00);
		rchk(8'h20, 8'h00);
	endtask

	task automatic t_rw;
		logic [7:0] wv [6] = '{8'hfd, 8'h81, 8'hfa, 8'hff, 8'hff, 8'hc0};
		logic [7:0] ev [6] = '{8'h05, 8'h81, 8'h02, 8'h7f, 8'h03, 8'hc0};
		for (int i = 0; i < 6; i++) begin
			wreg(8'h13 + 8'(i), wv[i]);
			rchk(8'h13 + 8'(i), ev[i]);
		end
		look(8'h00, 2'b00);
		chk("y_trim", 11'h5a5, cfg.y_trim_value);
		chk("z_trim", 11'h281, cfg.z_trim_value);
		chk("self_test", 11'h1, cfg.self_test_on);
		chk("three_wire", 11'h1, cfg.three_wire_select);
		chk("mode", 11'h3, cfg.mode);
		chk("bandwidth", 11'h1, cfg.filter_bandwidth_select);
		chk("thr_sign", 11'h1, cfg.threshold_sign_option);
	endtask

	task automatic t_range;
		logic [6:0] cpg [3] = '{7'd16, 7'd64, 7'd32};
		for (int i = 0; i < 3; i++) begin
			wreg(8'h16, 8'(i * 5));
			look(8'h00, 2'b00);
			chk("mode", 11'(i), cfg.mode);
			chk("counts", 11'(cpg[i]), cfg.counts_per_g);
			chk("self_test", 11'h0, cfg.self_test_on);
			chk("three_wire", 11'h0, cfg.three_wire_select);
		end
	endtask

	task automatic t_irq;
		wreg(8'h16, 8'h00);
		wreg(8'h18, 8'h00);
		core.hit(acr_evt_t'(9'h100));
		look(8'h81, 2'b10);
		wreg(8'h17, 8'h00);
		look(8'h81, 2'b10);
		wreg(8'h17, 8'h01);
		look(8'h00, 2'b00);
		wreg(8'h18, 8'h03);
		core.hit(acr_evt_t'(9'h080));
		look(8'h42, 2'b10);
		wreg(8'h17, 8'h01);
		look(8'h42, 2'b10);
		wreg(8'h17, 8'h02);
		look(8'h00, 2'b00);
		wreg(8'h18, 8'h08);
		core.hit(acr_evt_t'(9'h100));
		look(8'h00, 2'b00);
		wreg(8'h18, 8'h04);
		core.hit(acr_evt_t'(9'h008));
		look(8'h07, 2'b11);
		wreg(8'h17, 8'h03);
		look(8'h00, 2'b00);
	endtask

	task automatic t_ready;
		wreg(8'h16, 8'h00);
		core.set_ready(1'b1);
		look(8'h00, 2'b10);
		wreg(8'h16, 8'h40);
		look(8'h00, 2'b00);
		core.set_ready(1'b0);
	endtask

	// Double pulse mode: second flag waits for a double hit
	task automatic t_double;
		wreg(8'h18, 8'h04);
		core.set_timing(1'b1, 1'b1);
		core.hit(acr_evt_t'(9'h008));
		look(8'h05, 2'b10);
		core.hit(acr_evt_t'(9'h009));
		look(8'h07, 2'b11);
		wreg(8'h17, 8'h03);
		look(8'h00, 2'b00);
		core.set_timing(1'b0, 1'b0);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence after five cycles of reset
	initial begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_rw();
		t_range();
		t_irq();
		t_ready();
		t_double();
		summarize();
	end

	// Watchdog: the run needs well under a thousand cycles
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
endmodule
